/* inc/pcp_pkg.sv */
// Constants, types and configuration struct of the PCM highway companding port
package pcp_pkg;
   localparam logic [9:0]  PCP_CNT_RST      = 10'h000;
   localparam logic [9:0]  PCP_CNT_MAX      = 10'h3ff;
   localparam logic [3:0]  PCP_LAST_WIDE    = 4'hf;
   localparam logic [3:0]  PCP_LAST_NARROW  = 4'h7;
   localparam logic [3:0]  PCP_LEFT_RST     = 4'h0;
   localparam logic [15:0] PCP_WORD_RST     = 16'h0000;
   localparam logic [13:0] PCP_MU_CLIP      = 14'h1fde;
   localparam logic [13:0] PCP_MU_BIAS      = 14'h0021;
   localparam logic [12:0] PCP_A_CLIP       = 13'h0fff;
   localparam logic [12:0] PCP_A_STEP_BIAS  = 13'h0020;
   localparam logic [7:0]  PCP_A_XOR        = 8'h55;
   localparam logic [7:0]  PCP_MU_FULL      = 8'h80;
   localparam logic [7:0]  PCP_A_FULL       = 8'haa;
   localparam logic [15:0] PCP_LIN_POS_FULL = 16'h7fff;
   localparam logic [15:0] PCP_MU_TOP_LIN   = 16'h7d7c;
   localparam logic [15:0] PCP_A_TOP_LIN    = 16'h7e00;

   typedef enum logic [1:0] {
      PCP_FMT_ALAW   = 2'b00,
      PCP_FMT_MULAW  = 2'b01,
      PCP_FMT_LINEAR = 2'b10
   } pcp_fmt_e;

   typedef enum logic {
      PCP_TX_IDLE  = 1'b0,
      PCP_TX_SHIFT = 1'b1
   } pcp_tx_e;

   typedef enum logic {
      PCP_RX_IDLE   = 1'b0,
      PCP_RX_ACTIVE = 1'b1
   } pcp_rx_e;

   typedef struct packed {
      logic [9:0] tx_slot_start_count;
      logic [9:0] rx_slot_start_count;
      logic       wide_sample_select;
      logic       double_clock_mode;
      logic       tristate_edge_select;
      pcp_fmt_e   companding_format_select;
   } pcp_cfg_s;
endpackage : pcp_pkg

/* hw/pcp_codec.sv */
// Companding encoder and expander for mu-law, A-law and linear samples
`timescale 1ns/1ps
module pcp_codec (
   input  wire pcp_pkg::pcp_fmt_e fmt,
   input  wire logic              wide,
   input  wire logic [15:0]       lin_in,
   input  wire logic [15:0]       code_in,
   output logic      [15:0]       tx_word,
   output logic      [15:0]       rx_lin
);
   import pcp_pkg::*;

   // (RQ15) Mu-law encode, biased segment search
   function automatic logic [7:0] mu_enc(input logic [15:0] s);
      logic        neg;
      logic [13:0] x;
      logic [13:0] mag;
      logic [13:0] b;
      logic [13:0] t;
      logic [2:0]  seg;
      neg = s[15];
      x   = s[15:2];
      mag = neg ? 14'(~x + 14'h0001) : x;
      if (mag > PCP_MU_CLIP) mag = PCP_MU_CLIP;
      b   = 14'(mag + PCP_MU_BIAS);
      seg = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (b[i+5]) seg = 3'(i);
      end
      t = b >> ({1'b0, seg} + 4'h1);
      // (RQ13) Sign low when negative, magnitude inverted
      return {~neg, ~seg, ~t[3:0]};
   endfunction : mu_enc

   // (RQ16) A-law encode over eight segments
   function automatic logic [7:0] a_enc(input logic [15:0] s);
      logic        neg;
      logic [12:0] x;
      logic [12:0] mag;
      logic [12:0] t;
      logic [2:0]  seg;
      neg = s[15];
      x   = s[15:3];
      mag = neg ? 13'(~x + 13'h0001) : x;
      if (mag > PCP_A_CLIP) mag = PCP_A_CLIP;
      seg = 3'h0;
      t   = mag >> 1;
      if (mag[11:5] != 7'h00) begin
         for (int i = 1; i < 8; i++) begin
            if (mag[i+4]) seg = 3'(i);
         end
         t = mag >> seg;
      end
      // (RQ14) Even bits inverted, sign low when negative
      return {~neg, seg, t[3:0]} ^ PCP_A_XOR;
   endfunction : a_enc

   // (RQ15) Mu-law expand to decode level
   function automatic logic [15:0] mu_dec(input logic [7:0] c);
      logic [2:0]  seg;
      logic [3:0]  st;
      logic [13:0] m;
      logic [15:0] v;
      seg = ~c[6:4];
      st  = ~c[3:0];
      m   = 14'({9'h000, st, 1'b1} + PCP_MU_BIAS - 14'h0001);
      m   = 14'(m << seg);
      m   = 14'(m - PCP_MU_BIAS);
      v   = {m, 2'b00};
      return c[7] ? v : 16'(~v + 16'h0001);
   endfunction : mu_dec

   // (RQ16) A-law expand to decode level
   function automatic logic [15:0] a_dec(input logic [7:0] c);
      logic [7:0]  t;
      logic [12:0] m;
      logic [15:0] v;
      t = c ^ PCP_A_XOR;
      m = {8'h00, t[3:0], 1'b1};
      if (t[6:4] != 3'h0) m = 13'((m + PCP_A_STEP_BIAS) << (t[6:4] - 3'h1));
      v = {m, 3'b000};
      return t[7] ? v : 16'(~v + 16'h0001);
   endfunction : a_dec

   // (RQ11) Format select, (RQ9) wide linear bypass, (RQ12) 8-bit code layout
   always_comb begin
      tx_word = {lin_in[15:8], 8'h00};
      rx_lin  = {code_in[7:0], 8'h00};
      if (wide) begin
         tx_word = lin_in;
         rx_lin  = code_in;
      end else if (fmt == PCP_FMT_MULAW) begin
         tx_word = {mu_enc(lin_in), 8'h00};
         rx_lin  = mu_dec(code_in[7:0]);
      end else if (fmt == PCP_FMT_ALAW) begin
         tx_word = {a_enc(lin_in), 8'h00};
         rx_lin  = a_dec(code_in[7:0]);
      end
   end
endmodule : pcp_codec

/* hw/pcp_port.sv */
// PCM highway timeslot port with companding stage
// Summary of operation
// (RQ1) Frames of 4 to 128 slots from clock/sync
// (RQ2) Master supplies bit clock at listed rates
// (RQ3) Separate transmit and receive start counts
// (RQ4) Start when count equals start; else none
// (RQ5) Short sync start 1, long sync start 0
// (RQ6) Second B channel uses start count 10
// (RQ7) Transmit output driven only during own sample
// (RQ8) Edge select picks release edge
// (RQ9) Wide select sends 16-bit linear samples
// (RQ10) Double clock holds each bit two cycles
// (RQ11) Mu-law, A-law or linear format select
// (RQ12) Code is sign, three segment, four step
// (RQ13) Mu-law inverts magnitude, full scale 80h
// (RQ14) A-law inverts even bits, full scale AAh
// (RQ15) Mu-law to 8159, top decodes 8031
// (RQ16) A-law to 4096, top decodes 4032
// (RQ17) Bit clock synchronous to 8 kHz sync
// (RQ18) Samples shifted most significant bit first
`timescale 1ns/1ps
module pcp_port (
   input  wire  logic              mclk,
   input  wire  logic              nrst,
   input  wire  logic              ce,
   input  wire  pcp_pkg::pcp_cfg_s cfg,
   input  wire  logic              pcm_bit_clock,
   input  wire  logic              frame_sync_pulse,
   input  wire  logic              receive_data_in,
   input  wire  logic [15:0]       tx_sample,
   output logic                    transmit_data_out,
   output logic                    transmit_data_oe,
   output logic                    tx_sample_taken,
   output logic [15:0]             rx_sample,
   output logic                    rx_sample_valid
);
   import pcp_pkg::*;

   logic        pclk_q, pclk_d, fs_prev_q, fs_prev_d, live_q, live_d;
   logic [9:0]  cnt_q, cnt_d;
   logic        rise, fall, fs_start, tx_hit, rx_hit, dbl, tri_late;
   logic [15:0] tx_word, rx_lin, rx_word;
   pcp_tx_e     tx_st_q, tx_st_d;
   logic [15:0] sh_q, sh_d;
   logic [3:0]  left_q, left_d;
   logic        half_q, half_d, tdo_q, tdo_d, oe_q, oe_d, taken_q, taken_d;
   pcp_rx_e     rx_st_q, rx_st_d;
   logic [15:0] rsh_q, rsh_d, rxs_q, rxs_d;
   logic [3:0]  rleft_q, rleft_d;
   logic        rhalf_q, rhalf_d, rvalid_q, rvalid_d;

   assign rise     = pcm_bit_clock & ~pclk_q;
   assign fall     = ~pcm_bit_clock & pclk_q;
   assign fs_start = rise & frame_sync_pulse & ~fs_prev_q;
   assign dbl      = cfg.double_clock_mode;
   assign tri_late = cfg.tristate_edge_select;
   assign rx_word  = {rsh_q[14:0], receive_data_in};

   pcp_codec u_codec (
      .fmt     (cfg.companding_format_select),
      .wide    (cfg.wide_sample_select),
      .lin_in  (tx_sample),
      .code_in (rx_word),
      .tx_word (tx_word),
      .rx_lin  (rx_lin)
   );

   // (RQ1) Bit counter restarted by frame sync
   // (RQ17) Counts rely on clock locked to sync
   always_comb begin
      pclk_d    = pcm_bit_clock;
      fs_prev_d = fs_prev_q;
      cnt_d     = cnt_q;
      live_d    = live_q;
      if (rise) begin
         fs_prev_d = frame_sync_pulse;
         // (RQ5) Sync edge marks count zero
         if (fs_start) begin
            cnt_d  = PCP_CNT_RST;
            live_d = 1'b1;
         end else if (live_q) begin
            if (cnt_q == PCP_CNT_MAX) live_d = 1'b0;
            else cnt_d = 10'(cnt_q + 10'h001);
         end
      end
   end

   // (RQ3) Independent start compares
   // (RQ4) Match starts transfer, beyond frame never
   // (RQ6) Any start count such as 10 accepted
   assign tx_hit = rise & live_d & (cnt_d == cfg.tx_slot_start_count);
   assign rx_hit = rise & live_d & (cnt_d == cfg.rx_slot_start_count);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pclk_q    <= 1'b0;
         fs_prev_q <= 1'b0;
         cnt_q     <= PCP_CNT_RST;
         live_q    <= 1'b0;
      end else if (ce) begin
         pclk_q    <= pclk_d;
         fs_prev_q <= fs_prev_d;
         cnt_q     <= cnt_d;
         live_q    <= live_d;
      end
   end

   // Transmit slot engine
   always_comb begin
      tx_st_d = tx_st_q;
      sh_d    = sh_q;
      left_d  = left_q;
      half_d  = half_q;
      tdo_d   = tdo_q;
      oe_d    = oe_q;
      taken_d = 1'b0;
      case (tx_st_q)
         PCP_TX_IDLE: begin
            // (RQ9) Width from wide select
            if (tx_hit) begin
               tx_st_d = PCP_TX_SHIFT;
               sh_d    = tx_word;
               tdo_d   = tx_word[15];
               oe_d    = 1'b1;
               left_d  = cfg.wide_sample_select ? PCP_LAST_WIDE : PCP_LAST_NARROW;
               half_d  = 1'b0;
               taken_d = 1'b1;
            end
         end
         PCP_TX_SHIFT: begin
            if (rise) begin
               // (RQ10) Hold bit for second clock
               if (dbl && !half_q) begin
                  half_d = 1'b1;
               end else begin
                  half_d = 1'b0;
                  // (RQ8) Late release on rising edge
                  if (left_q == PCP_LEFT_RST) begin
                     tx_st_d = PCP_TX_IDLE;
                     oe_d    = 1'b0;
                     tdo_d   = 1'b0;
                  end else begin
                     // (RQ18) Next lower bit out
                     sh_d   = {sh_q[14:0], 1'b0};
                     tdo_d  = sh_q[14];
                     left_d = 4'(left_q - 4'h1);
                  end
               end
            // (RQ8) Early release on falling edge of last bit
            end else if (fall && !tri_late && left_q == PCP_LEFT_RST && (!dbl || half_q)) begin
               tx_st_d = PCP_TX_IDLE;
               oe_d    = 1'b0;
               tdo_d   = 1'b0;
            end
         end
         default: begin
            tx_st_d = PCP_TX_IDLE;
            oe_d    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tx_st_q <= PCP_TX_IDLE;
         sh_q    <= PCP_WORD_RST;
         left_q  <= PCP_LEFT_RST;
         half_q  <= 1'b0;
         tdo_q   <= 1'b0;
         oe_q    <= 1'b0;
         taken_q <= 1'b0;
      end else if (ce) begin
         tx_st_q <= tx_st_d;
         sh_q    <= sh_d;
         left_q  <= left_d;
         half_q  <= half_d;
         tdo_q   <= tdo_d;
         oe_q    <= oe_d;
         taken_q <= taken_d;
      end
   end

   // Receive slot engine, samples on falling edges
   always_comb begin
      rx_st_d  = rx_st_q;
      rsh_d    = rsh_q;
      rleft_d  = rleft_q;
      rhalf_d  = rhalf_q;
      rxs_d    = rxs_q;
      rvalid_d = 1'b0;
      case (rx_st_q)
         PCP_RX_IDLE: begin
            if (rx_hit) begin
               rx_st_d = PCP_RX_ACTIVE;
               rleft_d = cfg.wide_sample_select ? PCP_LAST_WIDE : PCP_LAST_NARROW;
               rhalf_d = 1'b0;
            end
         end
         PCP_RX_ACTIVE: begin
            if (fall) begin
               // (RQ10) Sample in second clock of bit
               if (dbl && !rhalf_q) begin
                  rhalf_d = 1'b1;
               end else begin
                  rhalf_d = 1'b0;
                  // (RQ18) Shift in behind earlier bits
                  rsh_d   = rx_word;
                  if (rleft_q == PCP_LEFT_RST) begin
                     rx_st_d  = PCP_RX_IDLE;
                     rxs_d    = rx_lin;
                     rvalid_d = 1'b1;
                  end else begin
                     rleft_d = 4'(rleft_q - 4'h1);
                  end
               end
            end
         end
         default: rx_st_d = PCP_RX_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rx_st_q  <= PCP_RX_IDLE;
         rsh_q    <= PCP_WORD_RST;
         rleft_q  <= PCP_LEFT_RST;
         rhalf_q  <= 1'b0;
         rxs_q    <= PCP_WORD_RST;
         rvalid_q <= 1'b0;
      end else if (ce) begin
         rx_st_q  <= rx_st_d;
         rsh_q    <= rsh_d;
         rleft_q  <= rleft_d;
         rhalf_q  <= rhalf_d;
         rxs_q    <= rxs_d;
         rvalid_q <= rvalid_d;
      end
   end

   // (RQ7) Output enable only from slot engine
   assign transmit_data_out = tdo_q;
   assign transmit_data_oe  = oe_q;
   assign tx_sample_taken   = taken_q;
   assign rx_sample         = rxs_q;
   assign rx_sample_valid   = rvalid_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_drive_on_match: assert property ($rose(oe_q) |-> $past(tx_hit) // RQ4
                                      && $past(cnt_d) == $past(cfg.tx_slot_start_count))
      else $error("transmit enable rose without start count match");
   a_idle_no_drive: assert property (tx_st_q == PCP_TX_IDLE |-> !oe_q) // RQ7
      else $error("transmit driven outside own slot");
   a_sync_zero_count: assert property (ce && fs_start |=> cnt_q == PCP_CNT_RST && live_q) // RQ5
      else $error("frame sync did not restart count");
   a_early_release: assert property (ce && fall && tx_st_q == PCP_TX_SHIFT && left_q == PCP_LEFT_RST // RQ8
                                     && !tri_late && (!dbl || half_q) |=> !oe_q)
      else $error("early release missed on falling edge");
   a_late_release: assert property (ce && rise && tx_st_q == PCP_TX_SHIFT && left_q == PCP_LEFT_RST // RQ8
                                    && (!dbl || half_q) |=> !oe_q && tx_st_q == PCP_TX_IDLE)
      else $error("late release missed on rising edge");
   a_msb_first_out: assert property ($rose(oe_q) |-> // RQ18
                                     tdo_q == ($past(tx_sample[15]) ^ ($past(!cfg.wide_sample_select)
                                     && $past(cfg.companding_format_select) inside {PCP_FMT_MULAW, PCP_FMT_ALAW})))
      else $error("first transmitted bit is not the msb");
   a_dbl_hold_bit: assert property (ce && rise && dbl && !half_q && tx_st_q == PCP_TX_SHIFT // RQ10
                                    |=> $stable(tdo_q) && $stable(left_q))
      else $error("bit changed inside double clock period");
   a_mu_full_code: assert property (cfg.companding_format_select == PCP_FMT_MULAW && !cfg.wide_sample_select // RQ13
                                    && tx_sample == PCP_LIN_POS_FULL |-> tx_word[15:8] == PCP_MU_FULL)
      else $error("mu-law full scale code wrong");
   a_a_full_code: assert property (cfg.companding_format_select == PCP_FMT_ALAW && !cfg.wide_sample_select // RQ14
                                   && tx_sample == PCP_LIN_POS_FULL |-> tx_word[15:8] == PCP_A_FULL)
      else $error("A-law full scale code wrong");
   a_mu_top_level: assert property (cfg.companding_format_select == PCP_FMT_MULAW && !cfg.wide_sample_select // RQ15
                                    && rx_word[7:0] == PCP_MU_FULL |-> rx_lin == PCP_MU_TOP_LIN)
      else $error("mu-law top segment decode wrong");
   a_a_top_level: assert property (cfg.companding_format_select == PCP_FMT_ALAW && !cfg.wide_sample_select // RQ16
                                   && rx_word[7:0] == PCP_A_FULL |-> rx_lin == PCP_A_TOP_LIN)
      else $error("A-law top segment decode wrong");
   a_wide_passthru: assert property (cfg.wide_sample_select |-> tx_word == tx_sample && rx_lin == rx_word) // RQ9
      else $error("wide mode not linear passthrough");

   c_tx_slot: cover property ($fell(oe_q));
   c_rx_sample: cover property (rvalid_q && cfg.wide_sample_select);
   c_dbl_slot: cover property ($rose(oe_q) && dbl);
   c_late_tri: cover property ($fell(oe_q) && tri_late);
endmodule : pcp_port

/* tb/pcp_hwy_master.sv */
// Highway master model: bit clock, frame sync and serial receive data
`timescale 1ns/1ps
module pcp_hwy_master (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [10:0] frame_bits,
   input  wire logic [9:0]  rx_start,
   input  wire logic [4:0]  rx_nbits,
   input  wire logic        rx_dbl,
   input  wire logic [15:0] rx_word,
   output logic             pcm_bit_clock,
   output logic             frame_sync_pulse,
   output logic             receive_data_in
);
   logic [3:0]  ph_q;
   logic [10:0] cnt_q;
   int          idx;

   // Bit index within the receive slot
   assign idx = (frame_sync_pulse ? 0 : int'(cnt_q) + 1) - int'(rx_start);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ph_q             <= 4'h0;
         cnt_q            <= 11'h000;
         pcm_bit_clock    <= 1'b0;
         frame_sync_pulse <= 1'b0;
         receive_data_in  <= 1'b0;
      end else begin
         ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
         if (ph_q == 4'h5) begin
            pcm_bit_clock <= 1'b1;
            cnt_q <= frame_sync_pulse ? 11'h000 : cnt_q + 11'h001;
            if (idx >= 0 && idx < (int'(rx_nbits) << rx_dbl)) begin
               receive_data_in <= rx_word[int'(rx_nbits) - 1 - (idx >> rx_dbl)];
            end else begin
               receive_data_in <= ~receive_data_in;
            end
         end
         if (ph_q == 4'hb) begin
            pcm_bit_clock    <= 1'b0;
            frame_sync_pulse <= (cnt_q == frame_bits - 11'h001);
         end
      end
   end
endmodule : pcp_hwy_master

/* tb/pcp_port_tb_top.sv */
// Self-checking bench of the PCM highway companding port
`timescale 1ns/1ps
module pcp_port_tb_top;
   import pcp_pkg::*;
   logic        mclk;
   logic        nrst;
   logic        ce;
   pcp_cfg_s    cfg;
   logic [15:0] tx_sample;
   logic [15:0] rx_sample;
   logic [15:0] rx_word;
   logic [15:0] got_rx;
   logic        transmit_data_out;
   logic        transmit_data_oe;
   logic        tx_sample_taken;
   logic        rx_sample_valid;
   logic        pcm_bit_clock;
   logic        frame_sync_pulse;
   logic        receive_data_in;
   logic        bck_q;
   logic [10:0] frame_bits;
   wire  [4:0]  rx_nbits = cfg.wide_sample_select ? 5'h10 : 5'h08;
   logic [31:0] cap;
   logic [31:0] seed;
   int          fails, tests_run, oe_cyc, nfall, rx_seen, taken_n, cyc;
   pcp_fmt_e    c_f  [6] = '{PCP_FMT_MULAW, PCP_FMT_ALAW, PCP_FMT_MULAW, PCP_FMT_ALAW, PCP_FMT_MULAW, PCP_FMT_ALAW};
   logic [15:0] c_tv [6] = '{16'h7fff, 16'h7fff, 16'h8000, 16'h8000, 16'h0000, 16'h0000};
   logic [15:0] c_cd [6] = '{16'h0080, 16'h00aa, 16'h0000, 16'h002a, 16'h00ff, 16'h00d5};
   logic [15:0] c_ln [6] = '{16'h7d7c, 16'h7e00, 16'h8284, 16'h8200, 16'h0000, 16'h0008};

   pcp_port u_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .cfg(cfg), .pcm_bit_clock(pcm_bit_clock),
      .frame_sync_pulse(frame_sync_pulse), .receive_data_in(receive_data_in), .tx_sample(tx_sample),
      .transmit_data_out(transmit_data_out), .transmit_data_oe(transmit_data_oe),
      .tx_sample_taken(tx_sample_taken), .rx_sample(rx_sample), .rx_sample_valid(rx_sample_valid));

   pcp_hwy_master u_hwy (.mclk(mclk), .nrst(nrst), .frame_bits(frame_bits),
      .rx_start(cfg.rx_slot_start_count), .rx_nbits(rx_nbits), .rx_dbl(cfg.double_clock_mode),
      .rx_word(rx_word), .pcm_bit_clock(pcm_bit_clock), .frame_sync_pulse(frame_sync_pulse),
      .receive_data_in(receive_data_in));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 80000) begin
         fails++;
         end_of_test();
      end
      bck_q <= pcm_bit_clock;
      if (transmit_data_oe === 1'b1) oe_cyc++;
      if (bck_q === 1'b1 && pcm_bit_clock === 1'b0 && transmit_data_oe === 1'b1) begin
         cap = {cap[30:0], transmit_data_out};
         nfall++;
      end
      if (tx_sample_taken === 1'b1) taken_n++;
      if (rx_sample_valid === 1'b1) begin
         rx_seen++;
         got_rx = rx_sample;
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [31:0] exp_cap(input logic [15:0] w, input int nb, input logic d);
      logic [31:0] r;
      r = 32'h0;
      for (int i = nb - 1; i >= 0; i--) begin
         r = {r[30:0], w[i]};
         if (d) r = {r[30:0], w[i]};
      end
      return r;
   endfunction : exp_cap

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_cnt(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test

   // One frame with fresh settings, then checks at the next sync
   task automatic xfer(input pcp_fmt_e f, input logic w, d, t, input logic [10:0] fb, input logic [9:0] ts, rs,
                       input logic [15:0] tv, rw, etx, erx, input int act);
      int nb;
      int n;
      nb = w ? 16 : 8;
      n = nb * (d ? 2 : 1);
      @(posedge frame_sync_pulse);
      @(posedge mclk);
      #1;
      cfg = '{ts, rs, w, d, t, f};
      tx_sample = tv;
      rx_word = rw;
      frame_bits = fb;
      cap = 32'h0;
      nfall = 0;
      oe_cyc = 0;
      rx_seen = 0;
      taken_n = 0;
      @(posedge frame_sync_pulse);
      repeat (2) @(posedge mclk);
      chk_cnt(nfall, act * n);
      chk_word(cap, act ? exp_cap(etx, nb, d) : 32'h0);
      chk_cnt(oe_cyc, act * ((n - 1) * 12 + (t ? 12 : 6)));
      chk_cnt(taken_n, act);
      chk_cnt(rx_seen, act);
      if (act) chk_word({16'h0, got_rx}, {16'h0, erx});
   endtask : xfer

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      cfg = '0;
      tx_sample = 16'h0;
      rx_word = 16'h0;
      frame_bits = 11'd32;
      seed = 32'h5ee5;
      repeat (3) @(posedge mclk);
      #1;
      nrst = 1'b1;
      for (int i = 0; i < 6; i++) begin
         xfer(c_f[i], 0, 0, 0, 11'd32, 10'd1, 10'd1, c_tv[i], c_cd[i], c_cd[i], c_ln[i],
              1);
      end
      xfer(PCP_FMT_LINEAR, 0, 0, 1, 11'd32, 10'd0, 10'd10, 16'ha5c3, 16'h0096, 16'h00a5, 16'h9600, 1);
      xfer(PCP_FMT_LINEAR, 0, 1, 0, 11'd32, 10'd3, 10'd5, 16'h3cff, 16'h00c3, 16'h003c, 16'hc300, 1);
      xfer(PCP_FMT_MULAW, 0, 0, 0, 11'd32, 10'd40, 10'd40, 16'h1234, 16'h0055, 16'h0, 16'h0, 0);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         xfer(seed[0] ? PCP_FMT_MULAW : PCP_FMT_ALAW, 1, seed[1], seed[2], 11'd64, {5'h0, seed[8:4]},
              {5'h0, seed[13:9]}, seed[31:16], seed[31:16] ^ seed[15:0], seed[31:16],
              seed[31:16] ^ seed[15:0], 1);
      end
      xfer(PCP_FMT_LINEAR, 0, 0, 1, 11'd1024, 10'd1000, 10'd1010, 16'h5a00, 16'h00e7, 16'h005a, 16'he700, 1);
      end_of_test();
   end
endmodule : pcp_port_tb_top
